// >>> design/dhc_defines.svh
// constants of the dds host pin control logic: offsets, fields, resets, timing counts
`ifndef DHC_DEFINES_SVH
`define DHC_DEFINES_SVH

// ==========================================================
// apb register offsets (byte addresses)
`define DHC_APB_CTRL       12'h000
`define DHC_APB_STATUS     12'h004
`define DHC_APB_ACT_BASE   12'h020
`define DHC_APB_ACT_HI     11
`define DHC_APB_ACT_LO     5

// ==========================================================
// ctrl register fields and reset
`define DHC_CTRL_SYNC_MASTER 0
`define DHC_CTRL_RST         1'b0

// ==========================================================
// serial frame: instruction byte then one 32-bit data word
`define DHC_SPI_READ_BIT   7
`define DHC_SPI_INSN_LAST  6'h07
`define DHC_SPI_DATA_FIRST 6'h08
`define DHC_SPI_FRAME_LAST 6'h27
`define DHC_SPI_FRAME_END  6'h28

// ==========================================================
// serial register indices and function register one fields
`define DHC_IDX_FR1        3'h0
`define DHC_IDX_FREQ       3'h1
`define DHC_IDX_PHASE      3'h2
`define DHC_IDX_AMPL       3'h3
`define DHC_FR1_PPC_HI     14
`define DHC_FR1_PPC_LO     12
`define DHC_FR1_RAMP_SDIO  0
`define DHC_FR1_SYNCCLK_OFF 1
`define DHC_FR1_MOD_EN     2
`define DHC_REG_RST        32'h0000_0000

// ==========================================================
// sync clock divider and pipeline latencies in system clocks
`define DHC_SYNC_RISE_PHASE  2'h2
`define DHC_SYNC_ALIGN_PHASE 2'h0
`define DHC_LAT_UPDATE     29
`define DHC_LAT_PROFILE    34

`endif

// >>> design/dhc_pkg.sv
// types of the dds host pin control logic
package dhc_pkg;

  typedef enum logic [1:0] {PIN_MOD, PIN_SWEEP, PIN_RAMP} dhc_pin_use_t;

  typedef struct packed {
    logic [31:0] freq;
    logic [13:0] phase;
    logic [9:0]  amp;
    logic [3:0]  prof;
  } dhc_dac_t;

  function automatic dhc_pin_use_t pin_use(input logic [2:0] profile_pin_config_field);
    dhc_pin_use_t u;
    u = PIN_MOD;
    if (profile_pin_config_field[2]) begin
      u = profile_pin_config_field[1] ? PIN_RAMP : PIN_SWEEP;
    end
    return u;
  endfunction

endpackage

// >>> design/dhc_pin_logic.sv
// pin level control logic: serial port, update strobe, profile pins, sync clock, apb view
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "dhc_defines.svh"

// Contract
// - master reset high forces serial buffer, active, mirror and ctrl registers to defaults
// - update strobe rising edge copies serial buffer into active registers
// - strobe and profile pins sampled at sync clock rise give fixed delay
// - sync clock runs at quarter system clock and can be disabled
// - profile pin use chosen by field bits 14:12 of function register one
// - profile pins act as shift keying selects, sweep controls or ramp controls
// - write data sampled on rising serial clock, read data driven on falling
// - serial port responds only while active low chip select is low
// - first serial data line serves the serial port only
// - serial line one serves the port or starts amplitude ramps, lines two and three only start amplitude ramps
// - clock mode select high enables oscillator, low bypasses it
// - master drives sync output, slave aligns on its sync input
// - update reaches the dac words 29 system clocks after the strobe
// - profile change reaches the dac frequency word after 34 system clocks
module dhc_pin_logic #(
  parameter int unsigned PIPE_DEPTH = `DHC_LAT_UPDATE - 1,
  parameter int unsigned SEL_DELAY  = `DHC_LAT_PROFILE - `DHC_LAT_UPDATE + 1
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic [3:0]  sdioIn,
  output logic      [3:0]  sdioOut,
  output logic      [3:0]  sdioOeN,
  input  wire logic        masterReset,
  input  wire logic        ioUpdate,
  input  wire logic [3:0]  profilePin,
  input  wire logic        syncIn,
  input  wire logic        clkModeSel,
  input  wire logic        externalPowerdownPin,
  output logic             syncClkOut,
  output logic             syncOut,
  output logic             oscEnable,
  output logic             powerDown,
  output logic      [31:0] dacFreqWord,
  output logic      [13:0] dacPhaseWord,
  output logic      [9:0]  dacAmpWord,
  output logic      [3:0]  dacProfile,
  output logic      [3:0]  modSel,
  output logic      [1:0]  sweepCtl,
  output logic      [1:0]  rampCtl
);

  if (PIPE_DEPTH < 1 || SEL_DELAY < 1) begin : g_bad_latency
    $error("latency parameters must be at least one");
  end

  // ==========================================================
  // serial link domain
  logic        linkRst;
  logic        mirRst;
  logic [5:0]  bitCnt_r;
  logic [38:0] shift_r;
  logic [39:0] shiftNxt;
  logic [7:0]  insn_r;
  logic [31:0] mirror_r [8];
  logic [2:0]  xferAddr_r;
  logic [31:0] xferData_r;
  logic        wrToggle_r;
  logic        wordDone;
  logic        rdPhase;
  logic [31:0] rdWord;
  logic [4:0]  rdIdx;
  logic        rampSdioL1_r;
  logic        rampSdioL2_r;
  logic [3:0]  sdioOut_r;
  logic [3:0]  sdioOeN_r;
  logic [31:0] fr1Act;
  logic        rampSdio;

  assign linkRst  = ~arst_n | csN;
  assign mirRst   = ~arst_n | masterReset;
  assign shiftNxt = {shift_r, sdioIn[0]};
  assign wordDone = (bitCnt_r == `DHC_SPI_FRAME_LAST) & ~insn_r[`DHC_SPI_READ_BIT];
  assign rdPhase  = insn_r[`DHC_SPI_READ_BIT] & (bitCnt_r >= `DHC_SPI_DATA_FIRST)
                    & (bitCnt_r <= `DHC_SPI_FRAME_LAST);
  assign rdWord   = mirror_r[insn_r[2:0]];
  assign rdIdx    = 5'(`DHC_SPI_FRAME_LAST - bitCnt_r);

  // bit counter and shifter, sampled on rising serial clock
  always_ff @(posedge sclk or posedge linkRst) begin
    if (linkRst) begin
      bitCnt_r <= 6'h00;
      shift_r  <= '0;
      insn_r   <= 8'h00;
    end else begin
      shift_r <= shiftNxt[38:0];
      if (bitCnt_r != `DHC_SPI_FRAME_END) begin
        bitCnt_r <= bitCnt_r + 6'h01;
      end
      if (bitCnt_r == `DHC_SPI_INSN_LAST) begin
        insn_r <= shiftNxt[7:0];
      end
    end
  end

  // readback mirror and word handed to the system domain
  always_ff @(posedge sclk or posedge mirRst) begin
    if (mirRst) begin
      for (int i = 0; i < 8; i++) begin
        mirror_r[i] <= `DHC_REG_RST;
      end
      xferAddr_r <= 3'h0;
      xferData_r <= `DHC_REG_RST;
      wrToggle_r <= 1'b0;
    end else if (wordDone) begin
      mirror_r[insn_r[2:0]] <= shiftNxt[31:0];
      xferAddr_r            <= insn_r[2:0];
      xferData_r            <= shiftNxt[31:0];
      wrToggle_r            <= ~wrToggle_r;
    end
  end

  // ramp-on-sdio mode brought into the link domain
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      rampSdioL1_r <= 1'b0;
      rampSdioL2_r <= 1'b0;
    end else begin
      rampSdioL1_r <= rampSdio;
      rampSdioL2_r <= rampSdioL1_r;
    end
  end

  // read data driven on falling serial clock
  always_ff @(negedge sclk or posedge linkRst) begin
    if (linkRst) begin
      sdioOut_r <= 4'h0;
      sdioOeN_r <= 4'hf;
    end else begin
      sdioOut_r[0] <= rdWord[rdIdx];
      sdioOeN_r[0] <= ~rdPhase;
      sdioOut_r[1] <= rdWord[rdIdx];
      sdioOeN_r[1] <= ~(rdPhase & ~rampSdioL2_r);
    end
  end

  assign sdioOut = sdioOut_r;
  assign sdioOeN = sdioOeN_r;

  // ==========================================================
  // pin synchronisers into the system domain
  localparam int unsigned NSYNC = 13;
  logic [NSYNC-1:0] syncIn1_r;
  logic [NSYNC-1:0] syncIn2_r;
  logic [NSYNC-1:0] pinRaw;
  logic             togPrev_r;
  logic             updS;
  logic [3:0]       profS;
  logic [2:0]       sdioS;
  logic             syncInS;
  logic             clkModeS;
  logic             extPdS;
  logic             mrstS;
  logic             togS;

  assign pinRaw = {ioUpdate, profilePin, sdioIn[3:1], syncIn, clkModeSel,
                   externalPowerdownPin, masterReset, wrToggle_r};
  assign {updS, profS, sdioS, syncInS, clkModeS, extPdS, mrstS, togS} = syncIn2_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      syncIn1_r <= '0;
      syncIn2_r <= '0;
      togPrev_r <= 1'b0;
    end else begin
      syncIn1_r <= pinRaw;
      syncIn2_r <= syncIn1_r;
      togPrev_r <= togS;
    end
  end

  // ==========================================================
  // sync clock divider and multi-device alignment
  logic [1:0] phase_r;
  logic [1:0] phaseNxt;
  logic       syncInPrev_r;
  logic       slaveAlign;
  logic       sampleNow;
  logic       syncMaster_r;
  logic       syncClkOut_r;
  logic       syncOut_r;

  assign slaveAlign = ~syncMaster_r & syncInS & ~syncInPrev_r;
  assign phaseNxt   = slaveAlign ? `DHC_SYNC_ALIGN_PHASE : phase_r + 2'h1;
  assign sampleNow  = ~slaveAlign & (phaseNxt == `DHC_SYNC_RISE_PHASE);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_r      <= 2'h0;
      syncInPrev_r <= 1'b0;
      syncClkOut_r <= 1'b0;
      syncOut_r    <= 1'b0;
    end else begin
      phase_r      <= phaseNxt;
      syncInPrev_r <= syncInS;
      syncClkOut_r <= phaseNxt[1] & ~fr1Act[`DHC_FR1_SYNCCLK_OFF];
      syncOut_r    <= syncMaster_r & phaseNxt[1];
    end
  end

  assign syncClkOut = syncClkOut_r;
  assign syncOut    = syncOut_r;

  // ==========================================================
  // serial buffer and active registers
  logic [31:0] bufReg_r [8];
  logic [31:0] actReg_r [8];
  logic        updSamp_r;
  logic        updEdge;
  logic        bufWrite;

  assign bufWrite = togS ^ togPrev_r;
  assign updEdge  = sampleNow & updS & ~updSamp_r;
  assign fr1Act   = actReg_r[`DHC_IDX_FR1];
  assign rampSdio = fr1Act[`DHC_FR1_RAMP_SDIO];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 8; i++) begin
        bufReg_r[i] <= `DHC_REG_RST;
        actReg_r[i] <= `DHC_REG_RST;
      end
      updSamp_r <= 1'b0;
    end else if (mrstS) begin
      for (int i = 0; i < 8; i++) begin
        bufReg_r[i] <= `DHC_REG_RST;
        actReg_r[i] <= `DHC_REG_RST;
      end
      updSamp_r <= 1'b0;
    end else begin
      if (bufWrite) begin
        bufReg_r[xferAddr_r] <= xferData_r;
      end
      if (updEdge) begin
        actReg_r <= bufReg_r;
      end
      if (sampleNow) begin
        updSamp_r <= updS;
      end
    end
  end

  // ==========================================================
  // profile pins, ramp lines, clock mode and power-down
  dhc_pkg::dhc_pin_use_t pinUse;
  logic [3:0] modSel_r;
  logic [1:0] sweepCtl_r;
  logic [1:0] rampCtl_r;
  logic [1:0] rampNxt;
  logic       oscEnable_r;
  logic       powerDown_r;

  assign pinUse  = dhc_pkg::pin_use(fr1Act[`DHC_FR1_PPC_HI:`DHC_FR1_PPC_LO]);
  assign rampNxt = rampSdio ? {sdioS[1] | sdioS[2], sdioS[0] | sdioS[2]}
                 : (sampleNow && pinUse == dhc_pkg::PIN_RAMP) ? profS[1:0] : rampCtl_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      modSel_r    <= 4'h0;
      sweepCtl_r  <= 2'h0;
      rampCtl_r   <= 2'h0;
      oscEnable_r <= 1'b0;
      powerDown_r <= 1'b0;
    end else begin
      if (sampleNow && pinUse == dhc_pkg::PIN_MOD) begin
        modSel_r <= profS;
      end
      if (sampleNow && pinUse == dhc_pkg::PIN_SWEEP) begin
        sweepCtl_r <= profS[1:0];
      end
      rampCtl_r   <= rampNxt;
      oscEnable_r <= clkModeS;
      powerDown_r <= extPdS;
    end
  end

  assign modSel    = modSel_r;
  assign sweepCtl  = sweepCtl_r;
  assign rampCtl   = rampCtl_r;
  assign oscEnable = oscEnable_r;
  assign powerDown = powerDown_r;

  // ==========================================================
  // matched latency pipeline towards the dac words
  logic [3:0]       selDly_r [SEL_DELAY];
  dhc_pkg::dhc_dac_t pipe_r  [PIPE_DEPTH];
  dhc_pkg::dhc_dac_t pipeIn;
  logic [3:0]       selLast;

  assign selLast      = selDly_r[SEL_DELAY-1];
  assign pipeIn.freq  = fr1Act[`DHC_FR1_MOD_EN] ? actReg_r[{1'b1, selLast[1:0]}]
                                                : actReg_r[`DHC_IDX_FREQ];
  assign pipeIn.phase = actReg_r[`DHC_IDX_PHASE][13:0];
  assign pipeIn.amp   = actReg_r[`DHC_IDX_AMPL][9:0];
  assign pipeIn.prof  = selLast;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < SEL_DELAY; i++) begin
        selDly_r[i] <= 4'h0;
      end
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_r[i] <= '0;
      end
    end else begin
      selDly_r[0] <= modSel_r;
      for (int i = 1; i < SEL_DELAY; i++) begin
        selDly_r[i] <= selDly_r[i-1];
      end
      pipe_r[0] <= pipeIn;
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe_r[i] <= pipe_r[i-1];
      end
    end
  end

  assign dacFreqWord  = pipe_r[PIPE_DEPTH-1].freq;
  assign dacPhaseWord = pipe_r[PIPE_DEPTH-1].phase;
  assign dacAmpWord   = pipe_r[PIPE_DEPTH-1].amp;
  assign dacProfile   = pipe_r[PIPE_DEPTH-1].prof;

  // ==========================================================
  // apb slave: one wait-free access phase after setup
  logic        setupPh;
  logic        accessDone;
  logic        isCtrl;
  logic        isStat;
  logic        isAct;
  logic        mapped;
  logic [31:0] statusWord;
  logic [31:0] readMux;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;

  assign setupPh    = psel & ~penable;
  assign accessDone = psel & penable & pready_r;
  assign isCtrl     = paddr == `DHC_APB_CTRL;
  assign isStat     = paddr == `DHC_APB_STATUS;
  assign isAct      = (paddr[`DHC_APB_ACT_HI:`DHC_APB_ACT_LO]
                      == 7'(`DHC_APB_ACT_BASE >> `DHC_APB_ACT_LO))
                      & (paddr[1:0] == 2'h0);
  assign mapped     = isCtrl | (~pwrite & (isStat | isAct));
  assign statusWord = {17'h00000, pinUse, rampCtl_r, sweepCtl_r, modSel_r, updSamp_r,
                       powerDown_r, oscEnable_r, syncClkOut_r, syncMaster_r};
  assign readMux    = isCtrl ? {31'h00000000, syncMaster_r}
                    : isStat ? statusWord
                    : isAct  ? actReg_r[paddr[4:2]] : 32'h00000000;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready_r     <= 1'b0;
      pslverr_r    <= 1'b0;
      prdata_r     <= 32'h00000000;
      syncMaster_r <= `DHC_CTRL_RST;
    end else begin
      pready_r <= setupPh;
      if (setupPh) begin
        pslverr_r <= ~mapped;
        prdata_r  <= pwrite ? 32'h00000000 : readMux;
      end
      if (mrstS) begin
        syncMaster_r <= `DHC_CTRL_RST;
      end else if (accessDone && pwrite && isCtrl) begin
        syncMaster_r <= pwdata[`DHC_CTRL_SYNC_MASTER];
      end
    end
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  // ==========================================================
  // assertions
  property p_rst_defaults;
    @(posedge clock) disable iff (!arst_n) mrstS |=> (fr1Act == `DHC_REG_RST);
  endproperty
  a_rst_defaults: assert property (p_rst_defaults) else $error("reset left a register");

  property p_update_copy;
    @(posedge clock) disable iff (!arst_n)
      updEdge && !mrstS |=> (actReg_r[`DHC_IDX_AMPL] == $past(bufReg_r[`DHC_IDX_AMPL]));
  endproperty
  a_update_copy: assert property (p_update_copy) else $error("update did not copy");

  property p_sample_rise;
    @(posedge clock) disable iff (!arst_n) updEdge |=> $rose(syncClkOut_r) || !syncClkOut_r;
  endproperty
  a_sample_rise: assert property (p_sample_rise) else $error("update off sync edge");

  property p_sync_period;
    @(posedge clock) disable iff (!arst_n)
      $rose(syncClkOut_r) && syncMaster_r && !fr1Act[`DHC_FR1_SYNCCLK_OFF]
      |-> ##1 syncClkOut_r ##1 !syncClkOut_r ##2 syncClkOut_r;
  endproperty
  a_sync_period: assert property (p_sync_period) else $error("sync clock not quarter");

  property p_mod_select;
    @(posedge clock) disable iff (!arst_n)
      sampleNow && pinUse == dhc_pkg::PIN_MOD |=> modSel_r == $past(profS);
  endproperty
  a_mod_select: assert property (p_mod_select) else $error("profile select missed");

  property p_sdio0_port;
    @(negedge sclk) disable iff (!arst_n) !sdioOeN_r[0] |-> insn_r[`DHC_SPI_READ_BIT];
  endproperty
  a_sdio0_port: assert property (p_sdio0_port) else $error("sdio0 driven outside read");

  property p_write_word;
    @(posedge sclk) disable iff (mirRst) wordDone |=> wrToggle_r != $past(wrToggle_r);
  endproperty
  a_write_word: assert property (p_write_word) else $error("serial word not handed over");

  property p_ramp_sdio;
    @(posedge clock) disable iff (!arst_n)
      rampSdio && sdioS[2] |=> rampCtl_r == 2'h3;
  endproperty
  a_ramp_sdio: assert property (p_ramp_sdio) else $error("sdio ramp not applied");

  property p_osc_enable;
    @(posedge clock) disable iff (!arst_n) clkModeS |=> oscEnable_r;
  endproperty
  a_osc_enable: assert property (p_osc_enable) else $error("oscillator not enabled");

  property p_update_latency;
    @(posedge clock) disable iff (!arst_n)
      updEdge |-> ##29 (dacAmpWord == $past(pipeIn.amp, 28));
  endproperty
  a_update_latency: assert property (p_update_latency) else $error("update latency wrong");

  property p_profile_latency;
    @(posedge clock) disable iff (!arst_n)
      $changed(modSel_r) |-> ##34 (dacProfile == $past(modSel_r, 34));
  endproperty
  a_profile_latency: assert property (p_profile_latency) else $error("profile latency wrong");

  property p_no_update_stable;
    @(posedge clock) disable iff (!arst_n) !updEdge && !mrstS |=> $stable(fr1Act);
  endproperty
  a_no_update_stable: assert property (p_no_update_stable) else $error("active changed");

  c_update:  cover property (@(posedge clock) disable iff (!arst_n) updEdge);
  c_profile: cover property (@(posedge clock) disable iff (!arst_n) $changed(modSel_r));
  c_write:   cover property (@(posedge sclk) disable iff (mirRst) wordDone);
  c_read:    cover property (@(negedge sclk) disable iff (!arst_n) !sdioOeN_r[0]);

endmodule

// >>> bench/dhc_host_model.sv
// host controller model: serial frames, update strobe, profile pins
`timescale 1ns/10ps
module dhc_host_model (
  input  wire logic       clock,
  output logic            sclk,
  output logic            csN,
  output logic [3:0]      sdioIn,
  input  wire logic [3:0] sdioOut,
  input  wire logic [3:0] sdioOeN,
  output logic            ioUpdate,
  output logic [3:0]      profilePin
);
  logic       hostBit;
  logic [3:1] rampIn;
  // line level from both parties; the device drives while its enable is low
  assign sdioIn = {rampIn, sdioOeN[0] ? hostBit : sdioOut[0]};
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    hostBit = 1'b0;
    rampIn = 3'h0;
    ioUpdate = 1'b0;
    profilePin = 4'h0;
  end
  // one 40-bit frame, clock stands still outside it; sel low keeps select high
  task automatic frame(input logic [7:0] insn, input logic [31:0] wd, input logic sel,
                       output logic [31:0] rd);
    logic [39:0] sh;
    sh = {insn, wd};
    rd = 32'h0;
    csN = ~sel;
    #6;
    for (int i = 39; i >= 0; i--) begin
      hostBit = sh[i];
      #6;
      sclk = 1'b1;
      if (i < 32) rd[i] = sdioIn[0];
      #6;
      sclk = 1'b0;
    end
    hostBit = ~hostBit;
    #6;
    csN = 1'b1;
    #700;
  endtask
  // update pulse launched at a system clock edge, held two sync periods
  task automatic update();
    @(posedge clock);
    ioUpdate <= 1'b1;
    repeat (8) @(posedge clock);
    ioUpdate <= 1'b0;
  endtask
  task automatic profile(input logic [3:0] p);
    @(posedge clock);
    profilePin <= p;
  endtask
  // levels on serial lines one to three, used as ramp inputs
  task automatic ramp(input logic [3:1] r);
    @(posedge clock);
    rampIn <= r;
  endtask
endmodule

// >>> bench/tb_top.sv
// top testbench: apb tasks, host model and scenario sequence
`timescale 1ns/10ps
`include "dhc_defines.svh"
module tb_top;
  logic        clock, arst_n, psel, penable, pwrite, pready, pslverr, sclk, csN;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, dacFreqWord;
  logic [3:0]  sdioIn, sdioOut, sdioOeN, profilePin, dacProfile, modSel;
  logic        masterReset, ioUpdate, syncIn, clkModeSel, externalPowerdownPin;
  logic        syncClkOut, syncOut, oscEnable, powerDown, err;
  logic [13:0] dacPhaseWord;
  logic [9:0]  dacAmpWord;
  logic [1:0]  sweepCtl, rampCtl;
  int          fails, checks, n, c0, c1;
  logic [2:0]  ppcs[3] = '{3'b000, 3'b100, 3'b110};

  dhc_pin_logic u_dut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .csN(csN), .sdioIn(sdioIn), .sdioOut(sdioOut),
    .sdioOeN(sdioOeN), .masterReset(masterReset), .ioUpdate(ioUpdate),
    .profilePin(profilePin), .syncIn(syncIn), .clkModeSel(clkModeSel),
    .externalPowerdownPin(externalPowerdownPin), .syncClkOut(syncClkOut),
    .syncOut(syncOut), .oscEnable(oscEnable), .powerDown(powerDown),
    .dacFreqWord(dacFreqWord), .dacPhaseWord(dacPhaseWord), .dacAmpWord(dacAmpWord),
    .dacProfile(dacProfile), .modSel(modSel), .sweepCtl(sweepCtl), .rampCtl(rampCtl));
  dhc_host_model u_host (.clock(clock), .sclk(sclk), .csN(csN), .sdioIn(sdioIn),
    .sdioOut(sdioOut), .sdioOeN(sdioOeN), .ioUpdate(ioUpdate), .profilePin(profilePin));

  // ==========================================================
  // clock, watchdog, report
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    #3000000;
    fails++;
    tally_and_finish();
  end
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // apb transfer and register compare
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(32'(err), 32'(e));
  endtask
  // counts rises of the sync clock and the sync output over 16 clocks
  task automatic countRises();
    logic pc, ps;
    c0 = 0;
    c1 = 0;
    @(posedge clock);
    pc = syncClkOut;
    ps = syncOut;
    repeat (16) begin
      @(posedge clock);
      if (syncClkOut && !pc) c0++;
      if (syncOut && !ps) c1++;
      pc = syncClkOut;
      ps = syncOut;
    end
  endtask
  task automatic swr(input logic [2:0] idx, input logic [31:0] d);
    logic [31:0] x;
    u_host.frame({5'h0, idx}, d, 1'b1, x);
  endtask

  // ==========================================================
  // scenarios
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {masterReset, syncIn, clkModeSel, externalPowerdownPin} = '0;
    fails = 0;
    checks = 0;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    chk(32'(sdioOeN), 32'hf);
    rdChk(`DHC_APB_CTRL, 32'h0, 1'b0);
    apb(1'b1, 12'h100, 32'h1);
    chk(32'(err), 32'h1);
    apb(1'b1, `DHC_APB_STATUS, 32'h1);
    chk(32'(err), 32'h1);
    countRises();
    chk(32'(c0), 32'h4);
    chk(32'(c1), 32'h0);
    apb(1'b1, `DHC_APB_CTRL, 32'h1);
    rdChk(`DHC_APB_CTRL, 32'h1, 1'b0);
    countRises();
    chk(32'(c1), 32'h4);
    for (int v = 0; v < 2; v++) begin
      clkModeSel <= v[0];
      externalPowerdownPin <= v[0];
      repeat (6) @(posedge clock);
      chk(32'(oscEnable), 32'(v));
      chk(32'(powerDown), 32'(v));
    end
    swr(`DHC_IDX_FREQ, 32'h1234_5678);
    swr(`DHC_IDX_PHASE, 32'h0000_1abc);
    swr(`DHC_IDX_AMPL, 32'h0000_02c5);
    u_host.frame(8'h01, 32'hdead_beef, 1'b0, rd);
    u_host.frame(8'h81, 32'h0, 1'b1, rd);
    chk(rd, 32'h1234_5678);
    rdChk(12'h024, 32'h0, 1'b0);
    chk(dacFreqWord, 32'h0);
    u_host.update();
    n = 9;
    while (dacFreqWord !== 32'h1234_5678 && n < 80) begin
      @(posedge clock);
      n++;
    end
    chk(32'(n >= 29 && n <= 40), 32'h1);
    chk(32'(dacPhaseWord), 32'h1abc);
    chk(32'(dacAmpWord), 32'h2c5);
    rdChk(12'h024, 32'h1234_5678, 1'b0);
    swr(3'h6, 32'hcafe_0006);
    foreach (ppcs[k]) begin
      swr(`DHC_IDX_FR1, {17'h0, ppcs[k], 12'h004});
      u_host.update();
      u_host.profile(4'ha);
      repeat (50) @(posedge clock);
      apb(1'b0, `DHC_APB_STATUS, 32'h0);
      chk(32'(rd[14:13]), 32'(k));
      if (k == 0) chk(32'(modSel), 32'ha);
      if (k == 0) chk(dacFreqWord, 32'hcafe_0006);
      if (k == 0) chk(32'(dacProfile), 32'ha);
      if (k == 1) chk(32'(sweepCtl), 32'h2);
      if (k == 2) chk(32'(rampCtl), 32'h2);
      u_host.profile(4'h0);
    end
    swr(`DHC_IDX_FR1, 32'h3);
    u_host.update();
    u_host.ramp(3'h1);
    repeat (10) @(posedge clock);
    chk(32'(rampCtl), 32'h1);
    u_host.ramp(3'h4);
    repeat (6) @(posedge clock);
    chk(32'(rampCtl), 32'h3);
    countRises();
    chk(32'(c0), 32'h0);
    masterReset <= 1'b1;
    repeat (4) @(posedge clock);
    masterReset <= 1'b0;
    repeat (4) @(posedge clock);
    rdChk(12'h024, 32'h0, 1'b0);
    rdChk(`DHC_APB_CTRL, 32'h0, 1'b0);
    u_host.frame(8'h81, 32'h0, 1'b1, rd);
    chk(rd, 32'h0);
    @(posedge clock);
    syncIn <= 1'b1;
    repeat (3) @(posedge clock);
    for (int j = 0; j < 4; j++) begin
      @(posedge clock);
      chk(32'(syncClkOut), 32'(j >= 2));
    end
    tally_and_finish();
  end
endmodule
